// File: verilog/lsd_deserializer.sv
// Top of the seven-to-one link deserializer
`timescale 1ns/1ps
module lsd_deserializer #(
   parameter int unsigned LANE_BITS = lsd_pkg::BITS_PER_LANE,
   parameter int unsigned LOCK_NEED = lsd_pkg::LOCK_FRAMES
) (
   input  wire logic                        core_clk,
   input  wire logic                        sys_rst,
   input  wire logic                        link_bit_clk,
   input  wire logic                        shutdown_clear_n,
   input  wire logic                        link_clock_in_pos,
   input  wire logic                        link_clock_in_neg,
   input  wire logic                        lane0_pos,
   input  wire logic                        lane0_neg,
   input  wire logic                        lane1_pos,
   input  wire logic                        lane1_neg,
   input  wire logic                        lane2_pos,
   input  wire logic                        lane2_neg,
   output logic [lsd_pkg::OUT_BITS-1:0]     parallel_out_bits,
   output logic                             parallel_clock_out,
   output logic                             clk_mult_enable,
   output logic                             lane_rx_enable,
   output logic                             link_locked
);
   import lsd_pkg::*;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // Rising edge of the sampled link clock marks the first bit of a frame
   function automatic logic frame_start(input logic [LANE_BITS-1:0] clk_bits);
      frame_start = clk_bits[NEWEST_POS] & ~clk_bits[PRIOR_POS];
   endfunction : frame_start

   // ----------------------------------------------------------------
   // Link domain: shutdown and reset crossing
   // ----------------------------------------------------------------
   logic link_run;
   logic link_rst;
   logic link_clr;

   lsd_sync u_link_run_sync (
      .clk  (link_bit_clk),
      .clr  (1'b0),
      .din  (shutdown_clear_n),
      .dout (link_run)
   );

   lsd_sync u_link_rst_sync (
      .clk  (link_bit_clk),
      .clr  (1'b0),
      .din  (sys_rst),
      .dout (link_rst)
   );

   // Every link register except the two crossing synchronisers clears while shutdown is low
   assign link_clr = link_rst | ~link_run;

   // ----------------------------------------------------------------
   // Link domain: lane receivers and shift registers
   // ----------------------------------------------------------------
   logic [DATA_LANES-1:0]  lane_pos;
   logic [DATA_LANES-1:0]  lane_neg;
   logic [LANE_BITS-1:0]   lane_bits [DATA_LANES];
   logic [LANE_BITS-1:0]   clk_lane_bits;

   assign lane_pos = {lane2_pos, lane1_pos, lane0_pos};
   assign lane_neg = {lane2_neg, lane1_neg, lane0_neg};

   // Receivers stay off while shutdown is low
   generate
      for (genvar g = 0; g < DATA_LANES; g++) begin : g_lane
         lsd_lane_rx #(
            .WIDTH (LANE_BITS)
         ) u_lane (
            .bit_clk    (link_bit_clk),
            .clr        (link_clr),
            .rx_enable  (link_run),
            .pin_pos    (lane_pos[g]),
            .pin_neg    (lane_neg[g]),
            .shift_bits (lane_bits[g])
         );
      end
   endgenerate

   // The clock lane goes through the same path so it stays bit-aligned
   lsd_lane_rx #(
      .WIDTH (LANE_BITS)
   ) u_clk_lane (
      .bit_clk    (link_bit_clk),
      .clr        (link_clr),
      .rx_enable  (link_run),
      .pin_pos    (link_clock_in_pos),
      .pin_neg    (link_clock_in_neg),
      .shift_bits (clk_lane_bits)
   );

   // The frame start shows up in the same bit period in which the new frame's first bit has
   // entered, so the finished frame is the register state one bit earlier
   logic [LANE_BITS-1:0] lane_prev [DATA_LANES];

   generate
      for (genvar g = 0; g < DATA_LANES; g++) begin : g_prev
         always_ff @(posedge link_bit_clk) begin
            if (link_clr) begin
               lane_prev[g] <= '0;
            end else begin
               lane_prev[g] <= lane_bits[g];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Link domain: frame alignment and lock
   // ----------------------------------------------------------------
   logic        at_frame;
   logic [3:0]  bit_cnt;
   logic [2:0]  good_frames;
   logic        link_lock;

   localparam logic [2:0] LOCK_NEED_CNT = 3'(LOCK_NEED);

   assign at_frame = frame_start(clk_lane_bits);

   // Bit periods since the last frame start; saturates if the clock lane stalls
   always_ff @(posedge link_bit_clk) begin
      if (link_clr) begin
         bit_cnt <= BIT_CNT_ZERO;
      end else if (at_frame) begin
         bit_cnt <= BIT_CNT_ZERO;
      end else if (bit_cnt != BIT_CNT_MAX) begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   // Lock needs a run of frames of exactly seven bit periods; a frame of
   // any other length means the link clock is outside the multiplier range
   always_ff @(posedge link_bit_clk) begin
      if (link_clr) begin
         good_frames <= 3'h0;
         link_lock   <= 1'b0;
      end else if (at_frame) begin
         if (bit_cnt == BIT_CNT_LAST) begin
            if (good_frames != LOCK_NEED_CNT) begin
               good_frames <= good_frames + 3'h1;
            end
            link_lock <= (good_frames == LOCK_NEED_CNT);
         end else begin
            good_frames <= 3'h0;
            link_lock   <= 1'b0;
         end
      end else if (bit_cnt == BIT_CNT_MAX) begin
         good_frames <= 3'h0;
         link_lock   <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Link domain: frame word hold and event toggle
   // ----------------------------------------------------------------
   logic [OUT_BITS-1:0] frame_word;
   logic                frame_tgl;

   // Word is held a whole frame, long enough for the core to sample it
   // after the toggle has crossed; this is why no word FIFO is needed
   always_ff @(posedge link_bit_clk) begin
      if (link_clr) begin
         frame_word <= '0;
         frame_tgl  <= 1'b0;
      end else if (at_frame && link_lock) begin
         frame_word[LANE0_BASE +: BITS_PER_LANE] <= lane_prev[0];
         frame_word[LANE1_BASE +: BITS_PER_LANE] <= lane_prev[1];
         frame_word[LANE2_BASE +: BITS_PER_LANE] <= lane_prev[2];
         frame_tgl  <= ~frame_tgl;
      end
   end

   // ----------------------------------------------------------------
   // Core domain: shutdown, lock and frame event crossing
   // ----------------------------------------------------------------
   logic core_run;
   logic core_clr;
   logic lock_sync;
   logic tgl_sync;
   logic tgl_seen;
   logic new_word;

   lsd_sync u_core_run_sync (
      .clk  (core_clk),
      .clr  (sys_rst),
      .din  (shutdown_clear_n),
      .dout (core_run)
   );

   assign core_clr = sys_rst | ~core_run;

   lsd_sync u_lock_sync (
      .clk  (core_clk),
      .clr  (core_clr),
      .din  (link_lock),
      .dout (lock_sync)
   );

   lsd_sync u_tgl_sync (
      .clk  (core_clk),
      .clr  (core_clr),
      .din  (frame_tgl),
      .dout (tgl_sync)
   );

   always_ff @(posedge core_clk) begin
      if (core_clr) begin
         tgl_seen <= 1'b0;
      end else begin
         tgl_seen <= tgl_sync;
      end
   end

   assign new_word = tgl_sync ^ tgl_seen;

   // ----------------------------------------------------------------
   // Core domain: power control outputs
   // ----------------------------------------------------------------
   // Clock multiplier and receivers are switched off while shutdown is low
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         clk_mult_enable <= 1'b0;
         lane_rx_enable  <= 1'b0;
      end else begin
         clk_mult_enable <= core_run;
         lane_rx_enable  <= core_run;
      end
   end

   always_ff @(posedge core_clk) begin
      if (core_clr) begin
         link_locked <= 1'b0;
      end else begin
         link_locked <= lock_sync;
      end
   end

   // ----------------------------------------------------------------
   // Core domain: parallel output register
   // ----------------------------------------------------------------
   // Frame word is stable a full frame after its toggle, so it is safe here
   always_ff @(posedge core_clk) begin
      if (core_clr) begin
         parallel_out_bits <= '0;
      end else if (new_word) begin
         parallel_out_bits <= frame_word;
      end
   end

   // ----------------------------------------------------------------
   // Core domain: output clock
   // ----------------------------------------------------------------
   lsd_oclk_state_t oclk_state;
   lsd_oclk_state_t next_oclk_state;
   logic [1:0]      high_cnt;

   // Clock rises with each new word and falls later, so data is settled
   // at the falling edge; one cycle per frame at the link rate
   always_comb begin
      next_oclk_state = oclk_state;
      unique case (oclk_state)
         LSD_OCLK_LOW: begin
            if (new_word) begin
               next_oclk_state = LSD_OCLK_HIGH;
            end
         end
         LSD_OCLK_HIGH: begin
            if (high_cnt == OUT_CLK_HIGH_CNT - 2'h1) begin
               next_oclk_state = LSD_OCLK_LOW;
            end
         end
         default: begin
            next_oclk_state = LSD_OCLK_LOW;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (core_clr) begin
         oclk_state <= LSD_OCLK_LOW;
      end else begin
         oclk_state <= next_oclk_state;
      end
   end

   always_ff @(posedge core_clk) begin
      if (core_clr) begin
         high_cnt <= 2'h0;
      end else if (oclk_state == LSD_OCLK_HIGH) begin
         high_cnt <= high_cnt + 2'h1;
      end else begin
         high_cnt <= 2'h0;
      end
   end

   // Registered so the output clock carries no combinational glitches
   always_ff @(posedge core_clk) begin
      if (core_clr) begin
         parallel_clock_out <= 1'b0;
      end else begin
         parallel_clock_out <= (next_oclk_state == LSD_OCLK_HIGH);
      end
   end

endmodule : lsd_deserializer

// File: pkg/lsd_pkg.sv
// Shared constants of the seven-to-one link deserializer
package lsd_pkg;

   // -----------------------------------------------------------------
   // Frame geometry
   // -----------------------------------------------------------------
   localparam int unsigned BITS_PER_LANE = 7;
   localparam int unsigned DATA_LANES    = 3;
   localparam int unsigned OUT_BITS      = BITS_PER_LANE * DATA_LANES;

   // Position of lane n in the parallel word is n * BITS_PER_LANE
   localparam int unsigned LANE0_BASE = 0;
   localparam int unsigned LANE1_BASE = 7;
   localparam int unsigned LANE2_BASE = 14;

   // Newest and next-newest sample positions in a lane shift register
   localparam int unsigned NEWEST_POS = BITS_PER_LANE - 1;
   localparam int unsigned PRIOR_POS  = BITS_PER_LANE - 2;

   // -----------------------------------------------------------------
   // Link clock range accepted by the clock multiplier
   // -----------------------------------------------------------------
   localparam int unsigned LINK_MIN_MHZ = 31;
   localparam int unsigned LINK_MAX_MHZ = 68;

   // -----------------------------------------------------------------
   // Timing on the core side
   // -----------------------------------------------------------------
   localparam int unsigned CORE_CLK_MHZ        = 10;
   localparam int unsigned CORE_CLK_PERIOD_NS  = 100;
   // Output clock high phase, in core cycles, after each new word
   localparam int unsigned OUT_CLK_HIGH_CYC    = 2;
   localparam logic [1:0]  OUT_CLK_HIGH_CNT    = 2'h2;

   // Frames of exactly seven bit periods counted before lock; lock is declared on the next such frame
   localparam int unsigned LOCK_FRAMES         = 4;
   localparam logic [2:0]  LOCK_FRAMES_CNT     = 3'h4;

   // Bit counter limits within one frame
   localparam logic [3:0]  BIT_CNT_ZERO        = 4'h0;
   localparam logic [3:0]  BIT_CNT_LAST        = 4'h6;
   localparam logic [3:0]  BIT_CNT_MAX         = 4'hf;

   // -----------------------------------------------------------------
   // Output clock state machine
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      LSD_OCLK_LOW  = 2'b01,
      LSD_OCLK_HIGH = 2'b10
   } lsd_oclk_state_t;

endpackage : lsd_pkg

// File: verilog/lsd_sync.sv
// Two-flop level synchroniser with synchronous clear
`timescale 1ns/1ps
module lsd_sync (
   input  wire logic clk,
   input  wire logic clr,
   input  wire logic din,
   output logic      dout
);
   import lsd_pkg::*;

   logic meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (clr) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule : lsd_sync

// File: verilog/lsd_lane_rx.sv
// One differential lane receiver with its serial-in shift register
`timescale 1ns/1ps
module lsd_lane_rx #(
   parameter int unsigned WIDTH = lsd_pkg::BITS_PER_LANE
) (
   input  wire logic             bit_clk,
   input  wire logic             clr,
   input  wire logic             rx_enable,
   input  wire logic             pin_pos,
   input  wire logic             pin_neg,
   output logic [WIDTH-1:0]      shift_bits
);
   import lsd_pkg::*;

   logic pos_sync;
   logic neg_sync;
   logic rx_bit;

   // Both legs are synchronised before any gate looks at them
   lsd_sync u_pos_sync (
      .clk  (bit_clk),
      .clr  (clr),
      .din  (pin_pos),
      .dout (pos_sync)
   );

   lsd_sync u_neg_sync (
      .clk  (bit_clk),
      .clr  (clr),
      .din  (pin_neg),
      .dout (neg_sync)
   );

   // A disabled receiver reads as low, so no toggling reaches the register
   assign rx_bit = rx_enable & pos_sync & ~neg_sync;

   // Newest bit enters at the top; after a frame the oldest sits at bit 0
   always_ff @(posedge bit_clk) begin
      if (clr) begin
         shift_bits <= '0;
      end else begin
         shift_bits <= {rx_bit, shift_bits[WIDTH-1:1]};
      end
   end

endmodule : lsd_lane_rx

// File: testbench/lsd_tx_model.sv
// Behavioural serializing transmitter that drives the three lanes and clock lane
`timescale 1ns/1ps
module lsd_tx_model (
   input  wire logic                         link_bit_clk,
   input  wire logic                         run,
   input  wire logic [lsd_pkg::OUT_BITS-1:0] word,
   output logic                              clk_pos,
   output logic                              clk_neg,
   output logic [2:0]                        lane_pos,
   output logic [2:0]                        lane_neg
);
   import lsd_pkg::*;
   logic [2:0]          bit_idx = 3'h0;
   logic [OUT_BITS-1:0] frame   = '0;
   initial begin
      clk_pos  = 1'b0;
      lane_pos = 3'h0;
   end
   assign clk_neg  = ~clk_pos;
   assign lane_neg = ~lane_pos;
   always @(posedge link_bit_clk) begin
      if (run) begin
         // Clock lane high for three bits: exactly one rising edge every seven bits
         clk_pos <= (bit_idx < 3'h3);
         for (int n = 0; n < 3; n++) begin
            // Oldest bit first, so it lands in bit 0 of its lane field
            lane_pos[n] <= (bit_idx == 3'h0) ? word[n*BITS_PER_LANE]
                                             : frame[n*BITS_PER_LANE + bit_idx];
         end
         if (bit_idx == 3'h0) begin
            frame <= word;
         end
         bit_idx <= (bit_idx == 3'h6) ? 3'h0 : bit_idx + 3'h1;
      end else begin
         // Stopped: clock lane still, data wanders so stale bits cannot look valid
         clk_pos  <= 1'b0;
         lane_pos <= ~lane_pos;
         bit_idx  <= 3'h0;
      end
   end
endmodule : lsd_tx_model

// File: testbench/lsd_monitor.sv
// Port-level assertions for the seven-to-one link deserializer
`timescale 1ns/1ps
module lsd_monitor #(
   parameter int unsigned LANE_BITS = lsd_pkg::BITS_PER_LANE,
   parameter int unsigned LOCK_NEED = lsd_pkg::LOCK_FRAMES
) (
   input wire logic                         core_clk,
   input wire logic                         sys_rst,
   input wire logic                         shutdown_clear_n,
   input wire logic [lsd_pkg::OUT_BITS-1:0] parallel_out_bits,
   input wire logic                         parallel_clock_out,
   input wire logic                         clk_mult_enable,
   input wire logic                         lane_rx_enable,
   input wire logic                         link_locked
);
   import lsd_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ---------------------------------------------------------------
   // Word delivery
   // ---------------------------------------------------------------
   chk_oclk_two_high: assert property ($rose(parallel_clock_out) |=>
      parallel_clock_out ##1 !parallel_clock_out) else $error("output clock high not two cycles");
   chk_word_at_fall: assert property ($fell(parallel_clock_out) && shutdown_clear_n |->
      $stable(parallel_out_bits)) else $error("word moved at output clock fall");
   chk_word_with_clk: assert property ($changed(parallel_out_bits) &&
      parallel_out_bits != '0 |-> $rose(parallel_clock_out)) else $error("word changed alone");
   chk_word_needs_lock: assert property ($rose(parallel_clock_out) |-> link_locked)
      else $error("word delivered without lock");
   chk_lock_after_on: assert property ($rose(link_locked) |-> $past(lane_rx_enable, 8))
      else $error("lock without enabled receivers");
   // ---------------------------------------------------------------
   // Shutdown and clear
   // ---------------------------------------------------------------
   chk_enables_equal: assert property (lane_rx_enable == clk_mult_enable)
      else $error("receiver and multiplier enables differ");
   chk_shutdown_off: assert property (!shutdown_clear_n [*8] |-> !clk_mult_enable)
      else $error("multiplier still on in shutdown");
   chk_awake_on: assert property (shutdown_clear_n [*8] |-> clk_mult_enable)
      else $error("multiplier off while awake");
   chk_clear_outputs: assert property (!shutdown_clear_n [*8] |->
      parallel_out_bits == '0 && !parallel_clock_out && !link_locked)
      else $error("outputs not cleared in shutdown");
   cov_word: cover property ($rose(parallel_clock_out));
   cov_lock_loss: cover property ($fell(link_locked));
   cov_power_off: cover property ($fell(lane_rx_enable));
endmodule : lsd_monitor

bind lsd_deserializer lsd_monitor #(.LANE_BITS(LANE_BITS), .LOCK_NEED(LOCK_NEED)) u_mon (
   .core_clk(core_clk), .sys_rst(sys_rst), .shutdown_clear_n(shutdown_clear_n),
   .parallel_out_bits(parallel_out_bits), .parallel_clock_out(parallel_clock_out),
   .clk_mult_enable(clk_mult_enable), .lane_rx_enable(lane_rx_enable),
   .link_locked(link_locked));

// File: testbench/tb_lvds_seven_to_one_deserializer.sv
// Self-checking bench for the seven-to-one link deserializer
`timescale 1ns/1ps
module tb_lvds_seven_to_one_deserializer;
   import lsd_pkg::*;
   logic                core_clk         = 1'b0;
   logic                link_bit_clk     = 1'b0;
   logic                sys_rst          = 1'b1;
   logic                shutdown_clear_n = 1'b1;
   logic                tx_run           = 1'b1;
   logic [OUT_BITS-1:0] tx_word          = '0;
   logic                ck_p;
   logic                ck_n;
   logic [2:0]          ln_p;
   logic [2:0]          ln_n;
   logic [OUT_BITS-1:0] par_bits;
   logic                par_clk;
   logic                mult_en;
   logic                rx_en;
   logic                locked;
   int                  failures = 0;
   int                  checks   = 0;
   int                  cycles   = 0;
   // Phases never coincide: link edges at 32+64k, core edges at 50+100m
   always #50 core_clk = ~core_clk;
   always #32 link_bit_clk = ~link_bit_clk;
   lsd_deserializer uut (
      .core_clk(core_clk), .sys_rst(sys_rst), .link_bit_clk(link_bit_clk),
      .shutdown_clear_n(shutdown_clear_n), .link_clock_in_pos(ck_p), .link_clock_in_neg(ck_n),
      .lane0_pos(ln_p[0]), .lane0_neg(ln_n[0]), .lane1_pos(ln_p[1]), .lane1_neg(ln_n[1]),
      .lane2_pos(ln_p[2]), .lane2_neg(ln_n[2]), .parallel_out_bits(par_bits),
      .parallel_clock_out(par_clk), .clk_mult_enable(mult_en), .lane_rx_enable(rx_en),
      .link_locked(locked));
   lsd_tx_model u_tx (
      .link_bit_clk(link_bit_clk), .run(tx_run), .word(tx_word), .clk_pos(ck_p),
      .clk_neg(ck_n), .lane_pos(ln_p), .lane_neg(ln_n));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic compare_val(input string what, input logic [20:0] seen,
                              input logic [20:0] expected);
      checks++;
      if (seen !== expected) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, expected, seen);
      end
   endtask : compare_val
   task automatic print_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   // Waits for n output clock rises; outputs are sampled on the falling core edge.
   // A new transmitter word can trail up to three rises of words already in flight.
   task automatic wait_words(input int n);
      @(negedge core_clk);
      for (int i = 0; i < n; i++) begin
         for (int k = 0; k < 200 && par_clk !== 1'b0; k++) @(negedge core_clk);
         for (int k = 0; k < 200 && par_clk !== 1'b1; k++) @(negedge core_clk);
      end
   endtask : wait_words
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_reset();
      @(negedge core_clk);
      compare_val("word in reset", par_bits, 21'h0);
      compare_val("flags in reset", 21'({mult_en, rx_en, locked, par_clk}), 21'h0);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (8) @(negedge core_clk);
      compare_val("power on", 21'({mult_en, rx_en}), 21'h3);
      $display("test_reset done");
   endtask : test_reset
   task automatic test_words();
      logic [20:0] words [3] = '{21'h00007f, 21'h1fc000, 21'h0a5b3c};
      foreach (words[i]) begin
         @(posedge core_clk);
         tx_word <= words[i];
         wait_words(4);
         compare_val("locked", 21'(locked), 21'h1);
         compare_val("word", par_bits, words[i]);
      end
      $display("test_words done");
   endtask : test_words
   task automatic test_shutdown();
      @(posedge core_clk);
      shutdown_clear_n <= 1'b0;
      repeat (10) @(negedge core_clk);
      compare_val("word cleared", par_bits, 21'h0);
      compare_val("clock and lock", 21'({par_clk, locked}), 21'h0);
      compare_val("power off", 21'({mult_en, rx_en}), 21'h0);
      @(posedge core_clk);
      shutdown_clear_n <= 1'b1;
      wait_words(4);
      compare_val("word after wake", par_bits, 21'h0a5b3c);
      $display("test_shutdown done");
   endtask : test_shutdown
   task automatic test_lock_loss();
      @(posedge core_clk);
      tx_run <= 1'b0;
      repeat (20) @(negedge core_clk);
      compare_val("lock dropped", 21'(locked), 21'h0);
      compare_val("word held", par_bits, 21'h0a5b3c);
      @(posedge core_clk);
      tx_word <= 21'h15aa55;
      tx_run  <= 1'b1;
      wait_words(4);
      compare_val("word after relock", par_bits, 21'h15aa55);
      $display("test_lock_loss done");
   endtask : test_lock_loss
   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         print_verdict();
      end
   end
   initial begin
      repeat (3) @(posedge core_clk);
      test_reset();
      test_words();
      test_shutdown();
      test_lock_loss();
      print_verdict();
   end
endmodule : tb_lvds_seven_to_one_deserializer
